/* hdl/pmp_defines.vh */
// Constants for the pattern memory playback block
`ifndef PMP_DEFINES_VH
`define PMP_DEFINES_VH
`define PMP_REG_CTRL 4'h0
`define PMP_REG_STAT 4'h1
`define PMP_REG_IRQ 4'h2
`define PMP_REG_MASK 4'h3
`define PMP_REG_LIST 4'h4
`define PMP_REG_BLOCK 4'h5
`define PMP_REG_COUNT 4'h6
`define PMP_REG_ERR 4'h7
`define PMP_REG_MEMSEL 4'h8
`define PMP_CTRL_PLAY 0
`define PMP_CTRL_CLEAR 1
`define PMP_CTRL_BLKGO 2
`define PMP_BIT_DATA 0
`define PMP_BIT_BURST 2
`define PMP_BIT_EVENT 6
`define PMP_BIT_RESTART 7
`define PMP_IRQ_LOADED 0
`define PMP_IRQ_OOM 1
`define PMP_IRQ_TOOMUCH 2
`define PMP_IRQ_RESTART 3
`define PMP_ERR_OOM 16'hFEBF
`define PMP_ERR_TOOMUCH 16'hFF21
`define PMP_SAMPLE_BYTES 4
`define PMP_CAP_MB_SMALL 32
`define PMP_CAP_MB_LARGE 64
`define PMP_ASCII_HASH 8'h23
`define PMP_ASCII_ZERO 8'h30
`endif

/* hdl/pmp_pattern_memory.v */
// Pattern memory loader and playback sequencer with Wishbone registers
`include "pmp_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module pmp_pattern_memory #(
  parameter AW = 10,
  parameter CAP_MB_SMALL = `PMP_CAP_MB_SMALL,
  parameter CAP_MB_LARGE = `PMP_CAP_MB_LARGE
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [5:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Playback
  input wire data_clk_en_i,
  output reg mod_data_o,
  output reg rf_gate_o,
  output reg event1_o,
  output reg restart_o,
  // Interrupt
  output reg irq_o
);
  localparam DEPTH = 1 << AW;
  localparam [AW:0] DEPTH_W = DEPTH;
  // Capacity in bytes for each memory option, 4 bytes per sample
  localparam [31:0] CAP_SMALL = CAP_MB_SMALL * 32'd1048576;
  localparam [31:0] CAP_LARGE = CAP_MB_LARGE * 32'd1048576;
  localparam [31:0] SAMPLE_BYTES = `PMP_SAMPLE_BYTES;
  // Block parser states
  localparam [3:0] S_IDLE = 4'b0001;
  localparam [3:0] S_NDIG = 4'b0010;
  localparam [3:0] S_CNT = 4'b0100;
  localparam [3:0] S_DATA = 4'b1000;

  reg [7:0] mem [0:DEPTH-1];
  reg [AW:0] wr_ptr_r;
  reg [AW-1:0] play_ptr_r;
  reg loaded_r;
  reg play_r;
  reg memsel_r;
  reg [3:0] irq_stat_r;
  reg [3:0] irq_mask_r;
  reg [15:0] err_r;
  reg [3:0] st_r;
  reg [3:0] ndig_r;
  reg [31:0] bcnt_r;
  reg [31:0] used_r;
  reg [7:0] rd_byte;
  reg [AW-1:0] play_ptr_nxt;
  reg play_wrap;
  reg [3:0] set_ev;
  reg wr_en;
  reg [7:0] wr_byte;
  reg wr_fail_mem;
  reg wr_fail_cap;
  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire bus_wr = bus_req & wb_we_i & wb_sel_i[0];
  wire [3:0] reg_idx = wb_adr_i[5:2];
  wire [31:0] cap = memsel_r ? CAP_LARGE : CAP_SMALL;
  wire active = play_r & loaded_r;
  wire [7:0] wdat = wb_dat_i[7:0];
  wire [7:0] dig_full = wdat - `PMP_ASCII_ZERO;
  wire [3:0] dig = dig_full[3:0];
  wire [31:0] bcnt_x10 = {bcnt_r[28:0], 3'b000} + {bcnt_r[30:0], 1'b0};

  // Byte write path shared by list and block loads
  always @* begin
    wr_en = 1'b0;
    wr_byte = wdat;
    if (bus_wr && reg_idx == `PMP_REG_LIST) begin
      wr_en = 1'b1;
    end
    if (bus_wr && reg_idx == `PMP_REG_BLOCK && st_r == S_DATA) begin
      wr_en = 1'b1;
    end
    wr_fail_mem = wr_ptr_r == DEPTH_W;
    wr_fail_cap = (used_r + SAMPLE_BYTES) > cap;
  end

  always @* begin
    set_ev = 4'h0;
    if (wr_en && wr_fail_cap) begin
      set_ev[`PMP_IRQ_OOM] = 1'b1;
    end else if (wr_en && wr_fail_mem) begin
      set_ev[`PMP_IRQ_TOOMUCH] = 1'b1;
    end else if (wr_en) begin
      set_ev[`PMP_IRQ_LOADED] = 1'b1;
    end
    if (active && data_clk_en_i && rd_byte[`PMP_BIT_RESTART]) begin
      set_ev[`PMP_IRQ_RESTART] = 1'b1;
    end
  end

  always @* begin
    rd_byte = mem[play_ptr_r];
  end

  // Next playback address, wraps on restart bit or past last stored byte
  always @* begin
    play_wrap = 1'b0;
    play_ptr_nxt = play_ptr_r + 1'b1;
    if (rd_byte[`PMP_BIT_RESTART])
      play_wrap = 1'b1;
    if (({1'b0, play_ptr_r} + 1'b1) >= wr_ptr_r)
      play_wrap = 1'b1;
    if (play_wrap)
      play_ptr_nxt = {AW{1'b0}};
  end

  always @(posedge clk_i) begin
    if (wr_en && !wr_fail_cap && !wr_fail_mem)
      mem[wr_ptr_r[AW-1:0]] <= wr_byte;
  end

  // Loader, registers and block parser
  always @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_r <= {(AW+1){1'b0}};
      used_r <= 32'h0;
      loaded_r <= 1'b0;
      play_r <= 1'b0;
      memsel_r <= 1'b0;
      irq_stat_r <= 4'h0;
      irq_mask_r <= 4'h0;
      err_r <= 16'h0000;
      st_r <= S_IDLE;
      ndig_r <= 4'h0;
      bcnt_r <= 32'h0;
    end else begin
      if (wr_en) begin
        if (wr_fail_cap)
          err_r <= `PMP_ERR_OOM;
        else if (wr_fail_mem)
          err_r <= `PMP_ERR_TOOMUCH;
        else begin
          wr_ptr_r <= wr_ptr_r + 1'b1;
          used_r <= used_r + SAMPLE_BYTES;
          loaded_r <= 1'b1;
        end
      end
      if (bus_wr) begin
        case (reg_idx)
          `PMP_REG_CTRL: begin
            play_r <= wdat[`PMP_CTRL_PLAY];
            if (wdat[`PMP_CTRL_CLEAR]) begin
              wr_ptr_r <= {(AW+1){1'b0}};
              used_r <= 32'h0;
              loaded_r <= 1'b0;
              err_r <= 16'h0000;
              st_r <= S_IDLE;
            end
          end
          `PMP_REG_MASK: begin
            irq_mask_r <= wdat[3:0];
          end
          `PMP_REG_MEMSEL: begin
            memsel_r <= wdat[0];
          end
          default: ;
        endcase
      end
      // Block header: hash, digit count, decimal count, payload
      if (bus_wr && reg_idx == `PMP_REG_BLOCK) begin
        case (st_r)
          S_IDLE: begin
            if (wdat == `PMP_ASCII_HASH)
              st_r <= S_NDIG;
          end
          S_NDIG: begin
            ndig_r <= dig;
            bcnt_r <= 32'h0;
            if (dig == 4'h0)
              st_r <= S_IDLE;
            else
              st_r <= S_CNT;
          end
          S_CNT: begin
            bcnt_r <= bcnt_x10 + {28'h0, dig};
            ndig_r <= ndig_r - 1'b1;
            if (ndig_r == 4'h1) begin
              if ((bcnt_x10 + {28'h0, dig}) == 32'h0)
                st_r <= S_IDLE;
              else
                st_r <= S_DATA;
            end
          end
          S_DATA: begin
            bcnt_r <= bcnt_r - 1'b1;
            if (bcnt_r == 32'h1)
              st_r <= S_IDLE;
          end
          default: st_r <= S_IDLE;
        endcase
      end
      // Sticky status, set wins over write-one clear
      if (bus_wr && reg_idx == `PMP_REG_IRQ) begin
        irq_stat_r <= (irq_stat_r & ~wdat[3:0]) | set_ev;
      end else begin
        irq_stat_r <= irq_stat_r | set_ev;
      end
    end
  end

  // Playback sequencer
  always @(posedge clk_i) begin
    if (rst_i) begin
      play_ptr_r <= {AW{1'b0}};
      mod_data_o <= 1'b0;
      rf_gate_o <= 1'b0;
      event1_o <= 1'b0;
      restart_o <= 1'b0;
    end else if (!active) begin
      play_ptr_r <= {AW{1'b0}};
      rf_gate_o <= 1'b0;
      mod_data_o <= 1'b0;
      restart_o <= 1'b0;
    end else if (data_clk_en_i) begin
      rf_gate_o <= rd_byte[`PMP_BIT_BURST];
      mod_data_o <= rd_byte[`PMP_BIT_DATA] & rd_byte[`PMP_BIT_BURST];
      if (rd_byte[`PMP_BIT_EVENT])
        event1_o <= ~event1_o;
      restart_o <= rd_byte[`PMP_BIT_RESTART];
      play_ptr_r <= play_ptr_nxt;
    end
  end

  // Bus answer, interrupt
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      irq_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
      irq_o <= |(irq_stat_r & irq_mask_r);
      // Read data only in the answer cycle, zero otherwise
      wb_dat_o <= 32'h0;
      if (bus_req && !wb_we_i) begin
        case (reg_idx)
          `PMP_REG_CTRL: begin
            wb_dat_o <= {31'h0, play_r};
          end
          `PMP_REG_STAT: begin
            wb_dat_o <= {24'h0, st_r, 1'b0, event1_o, active, loaded_r};
          end
          `PMP_REG_IRQ: begin
            wb_dat_o <= {28'h0, irq_stat_r};
          end
          `PMP_REG_MASK: begin
            wb_dat_o <= {28'h0, irq_mask_r};
          end
          `PMP_REG_COUNT: begin
            wb_dat_o <= {{(31-AW){1'b0}}, wr_ptr_r};
          end
          `PMP_REG_ERR: begin
            wb_dat_o <= {16'h0, err_r};
          end
          `PMP_REG_MEMSEL: begin
            wb_dat_o <= {31'h0, memsel_r};
          end
          default: begin
            wb_dat_o <= 32'h0;
          end
        endcase
      end
    end
  end
endmodule // pmp_pattern_memory
`default_nettype wire

/* verification/pmp_host_model.sv */
// Host model issuing classic Wishbone register cycles
`timescale 1ns/1ps
`default_nettype none
module pmp_host_model (
  // Clock, reset and command
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic we_i,
  input wire logic [5:0] adr_i,
  input wire logic [7:0] dat_i,
  // Wishbone master
  input wire logic ack_i,
  input wire logic [31:0] rd_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [5:0] adr_o,
  output logic [31:0] dat_o,
  // Completion
  output logic done_o,
  output logic [31:0] q_o
);
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    if (rst_i) begin
      {cyc_o, stb_o, we_o, adr_o, dat_o, q_o} <= '0;
    end else if (go_i && !cyc_o) begin
      {cyc_o, stb_o, we_o, adr_o} <= {2'b11, we_i, adr_i};
      dat_o <= {24'h0, dat_i};
    end else if (cyc_o && ack_i) begin
      {cyc_o, stb_o} <= 2'b00;
      q_o <= rd_i;
      dat_o <= ~dat_o;
      done_o <= 1'b1;
    end
  end
endmodule // pmp_host_model
`default_nettype wire

/* verification/pmp_pattern_memory_assertions.sv */
// Bus and playback checker for the pattern memory block
`timescale 1ns/1ps
`default_nettype none
module pmp_checker (
  // Watched ports
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic data_clk_en_i,
  input wire logic mod_data_o,
  input wire logic rf_gate_o,
  input wire logic event1_o,
  input wire logic restart_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
  a_ack_timely: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  a_rdata_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("dat");
  a_data_gated: assert property (mod_data_o |-> rf_gate_o) else $error("gate");
  a_event_on_clk: assert property ($changed(event1_o) |-> $past(data_clk_en_i))
    else $error("event");
  a_rf_on_clk: assert property ($rose(rf_gate_o) |-> $past(data_clk_en_i))
    else $error("rf");
  a_restart_clk: assert property ($rose(restart_o) |-> $past(data_clk_en_i))
    else $error("restart");
  a_quiet_reset: assert property ($fell(rst_i) |-> !(rf_gate_o | event1_o | restart_o))
    else $error("quiet");
  c_burst: cover property (rf_gate_o && mod_data_o);
  c_restart: cover property ($rose(restart_o));
  c_event: cover property ($changed(event1_o));
endmodule // pmp_checker
bind pmp_pattern_memory pmp_checker u_pmp_checker (.*);
`default_nettype wire

/* verification/tb_pmp_pattern_memory.sv */
// Self-checking bench for pattern memory playback
`timescale 1ns/1ps
`default_nettype none
`include "pmp_defines.vh"
module tb_pmp_pattern_memory;
  logic clk_i = 0, rst_i = 1, go = 0, gwe = 0, en = 0, done, cyc, stb, we, ack;
  logic md, rf, ev, rs, irq;
  logic [5:0] gadr = 0, adr;
  logic [7:0] gdat = 0;
  logic [31:0] wdat, rdat, q;
  int errors = 0, checks = 0;
  always #12.5 clk_i = ~clk_i;
  pmp_pattern_memory #(.AW(4)) u_pmp_pattern_memory (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .data_clk_en_i(en),
    .mod_data_o(md), .rf_gate_o(rf), .event1_o(ev), .restart_o(rs), .irq_o(irq));
  pmp_host_model u_pmp_host_model (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .we_i(gwe),
    .adr_i(gadr), .dat_i(gdat), .ack_i(ack), .rd_i(rdat), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .dat_o(wdat), .done_o(done), .q_o(q));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task bus(input logic w, input logic [3:0] r, input logic [7:0] d);
    int i;
    @(posedge clk_i);
    go <= 1;
    gwe <= w;
    gadr <= {r, 2'b00};
    gdat <= d;
    @(posedge clk_i);
    go <= 0;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      #1;
      if (done === 1'b1) break;
    end
    if (i == 20) errors++;
  endtask
  task rdc(input logic [3:0] r, input logic [31:0] e);
    bus(0, r, 8'h00);
    chk(q, e);
  endtask
  task step(input logic [3:0] e);
    @(posedge clk_i);
    en <= 1;
    @(posedge clk_i);
    en <= 0;
    #1;
    chk({28'h0, md, rf, ev, rs}, {28'h0, e});
  endtask
  task t_load;
    chk({28'h0, md, rf, ev, rs}, 32'h0);
    bus(1, `PMP_REG_MEMSEL, 8'h00);
    bus(1, `PMP_REG_LIST, 8'h15);
    bus(1, `PMP_REG_LIST, 8'h50);
    bus(1, `PMP_REG_LIST, 8'h94);
    rdc(`PMP_REG_COUNT, 32'h3);
    rdc(`PMP_REG_STAT, 32'h11);
    step(4'b0000);
  endtask
  task t_play;
    bus(1, `PMP_REG_MASK, 8'h08);
    bus(1, `PMP_REG_CTRL, 8'h01);
    step(4'b1100);
    step(4'b0010);
    step(4'b0111);
    rdc(`PMP_REG_IRQ, 32'h09);
    chk(irq, 1'b1);
    step(4'b1110);
    bus(1, `PMP_REG_IRQ, 8'h0F);
    chk(irq, 1'b0);
  endtask
  task t_block;
    bus(1, `PMP_REG_CTRL, 8'h02);
    bus(1, `PMP_REG_BLOCK, `PMP_ASCII_HASH);
    bus(1, `PMP_REG_BLOCK, 8'h31);
    bus(1, `PMP_REG_BLOCK, 8'h32);
    bus(1, `PMP_REG_BLOCK, 8'h00);
    bus(1, `PMP_REG_BLOCK, 8'hFF);
    rdc(`PMP_REG_COUNT, 32'h2);
  endtask
  task t_full;
    repeat (15) bus(1, `PMP_REG_LIST, 8'h14);
    rdc(`PMP_REG_COUNT, 32'h10);
    rdc(`PMP_REG_ERR, 32'hFF21);
    bus(1, `PMP_REG_MASK, 8'h04);
    chk(irq, 1'b1);
    bus(1, `PMP_REG_MEMSEL, 8'h01);
    rdc(`PMP_REG_MEMSEL, 32'h1);
    rdc(4'hF, 32'h0);
  endtask
  task finish_test;
    if (errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #400000;
    errors++;
    finish_test;
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    t_load;
    t_play;
    t_block;
    t_full;
    finish_test;
  end
endmodule // tb_pmp_pattern_memory
`default_nettype wire
